// ---- verilog/sad_pkg.sv ----
// Package for the system address decoder: address map and select types
package sad_pkg;
	localparam logic [31:0] SAD_FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] SAD_FLASH_LAST = 32'h07ff_ffff;
	localparam logic [31:0] SAD_VECTOR_BYTES = 32'h0000_00c4;
	localparam logic [31:0] SAD_SRAML_BASE = 32'h1fff_fc00;
	localparam logic [31:0] SAD_SRAMU_BASE = 32'h2000_0000;
	localparam logic [31:0] SAD_SRAMU_LAST = 32'h2000_0bff;
	localparam logic [31:0] SAD_BRIDGE_BASE = 32'h4000_0000;
	localparam logic [31:0] SAD_BRIDGE_LAST = 32'h4007_ffff;
	localparam logic [31:0] SAD_GPIO_BASE = 32'h400f_f000;
	localparam logic [31:0] SAD_GPIO_LAST = 32'h400f_ffff;
	localparam logic [31:0] SAD_BITMAN_BASE = 32'h4400_0000;
	localparam logic [31:0] SAD_BITMAN_LAST = 32'h5fff_ffff;
	localparam logic [31:0] SAD_PPB_BASE = 32'he000_0000;
	localparam logic [31:0] SAD_PPB_LAST = 32'he00f_ffff;
	localparam logic [31:0] SAD_TRACE_BASE = 32'hf000_0000;
	localparam logic [31:0] SAD_TRACE_LAST = 32'hf000_3fff;
	localparam logic [31:0] SAD_DIRECT_BASE = 32'hf800_0000;
	localparam logic [31:0] SAD_DIRECT_LAST = 32'hffff_ffff;
	localparam logic [6:0] SAD_GPIO_SLOT = 7'h0f;
	localparam int SAD_SLOT_COUNT = 128;
	localparam int SAD_ONPLAT_SLOTS = 32;
	localparam int SAD_SLOT_SHIFT = 12;

	// One-hot-free encoding of the chosen slave
	typedef enum logic [3:0] {
		SAD_SEL_NONE = 4'h0,
		SAD_SEL_FLASH = 4'h1,
		SAD_SEL_SRAML = 4'h2,
		SAD_SEL_SRAMU = 4'h3,
		SAD_SEL_BRIDGE = 4'h4,
		SAD_SEL_BITMAN = 4'h5,
		SAD_SEL_PPB = 4'h6,
		SAD_SEL_TRACE = 4'h7,
		SAD_SEL_DIRECT = 4'h8
	} sad_sel_type;

	typedef struct packed {
		logic valid;
		logic is_dma;
		logic write;
		logic [31:0] addr;
	} sad_req_type;

	typedef struct packed {
		logic valid;
		sad_sel_type sel;
		logic [7:0] slot;
		logic [11:0] offset;
		logic vector;
		logic error;
	} sad_resp_type;
endpackage

// ---- verilog/sad_decoder.sv ----
// System address decoder with peripheral bridge slot decode
//
// Contract
// - Decode full 4 GB, 32-bit address space
// - Low range routes to flash from zero
// - First 196 flash bytes are vectors
// - Both SRAM halves decoded, contiguous block
// - Bridge reached by core and DMA
// - 32 on-platform 4 KB slot enables
// - 96 off-platform 4 KB slot enables
// - Slot 128 selects GPIO, aliases 15
// - Core-only direct single-cycle GPIO port
// - Core-only bit manipulation alias, slots 0-127
// - Full bit ops on GPIO via slot 15
// - Private, trace, ROM, misc core only
// - Flash beyond present size errors
// - Flash read during command errors
// - SRAM beyond present size errors
// - Cleared clock gate disables slot
// - Unimplemented or disabled slot errors
// - Unimplemented offset in slot errors
`timescale 1ns/1ps
module sad_decoder
	import sad_pkg::*;
#(
	parameter logic [31:0] FLASH_SIZE = 32'h0000_8000,
	parameter logic [31:0] SRAML_SIZE = 32'h0000_0400,
	parameter logic [31:0] SRAMU_SIZE = 32'h0000_0c00,
	parameter logic [128:0] SLOT_PRESENT = {129{1'b1}},
	parameter logic [11:0] SLOT_SPAN = 12'hfff
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Request from the bus masters
	input wire sad_req_type req_i,
	// Module clock gates and flash status
	input wire logic [128:0] slot_clk_gate_i,
	input wire logic flash_cmd_busy_i,
	// Decoded answer
	output sad_resp_type resp_o,
	output logic [128:0] slot_enable_o,
	output logic bitman_gpio_full_o
);
	// Range hits; the whole 32-bit space is classified
	wire logic [31:0] a = req_i.addr;
	wire logic hit_flash;
	wire logic hit_sraml;
	wire logic hit_sramu;
	wire logic hit_bridge;
	wire logic hit_gpio;
	wire logic hit_bitman;
	wire logic hit_ppb;
	wire logic hit_trace;
	wire logic hit_direct;
	sad_range_hit #(.LO(SAD_FLASH_BASE), .HI(SAD_FLASH_LAST)) u_hit_flash (
		.addr_i(a),
		.hit_o(hit_flash)
	);
	sad_range_hit #(.LO(SAD_SRAML_BASE), .HI(SAD_SRAMU_BASE - 32'h0000_0001)) u_hit_sraml (
		.addr_i(a),
		.hit_o(hit_sraml)
	);
	sad_range_hit #(.LO(SAD_SRAMU_BASE), .HI(SAD_SRAMU_LAST)) u_hit_sramu (
		.addr_i(a),
		.hit_o(hit_sramu)
	);
	sad_range_hit #(.LO(SAD_BRIDGE_BASE), .HI(SAD_BRIDGE_LAST)) u_hit_bridge (
		.addr_i(a),
		.hit_o(hit_bridge)
	);
	sad_range_hit #(.LO(SAD_GPIO_BASE), .HI(SAD_GPIO_LAST)) u_hit_gpio (
		.addr_i(a),
		.hit_o(hit_gpio)
	);
	sad_range_hit #(.LO(SAD_BITMAN_BASE), .HI(SAD_BITMAN_LAST)) u_hit_bitman (
		.addr_i(a),
		.hit_o(hit_bitman)
	);
	sad_range_hit #(.LO(SAD_PPB_BASE), .HI(SAD_PPB_LAST)) u_hit_ppb (
		.addr_i(a),
		.hit_o(hit_ppb)
	);
	sad_range_hit #(.LO(SAD_TRACE_BASE), .HI(SAD_TRACE_LAST)) u_hit_trace (
		.addr_i(a),
		.hit_o(hit_trace)
	);
	sad_range_hit #(.LO(SAD_DIRECT_BASE), .HI(SAD_DIRECT_LAST)) u_hit_direct (
		.addr_i(a),
		.hit_o(hit_direct)
	);
	wire logic core_only = hit_bitman | hit_ppb | hit_trace | hit_direct;

	// Present-memory bounds; SRAM halves meet at the upper base
	wire logic flash_absent = a >= SAD_FLASH_BASE + FLASH_SIZE;
	wire logic sraml_absent = a < SAD_SRAMU_BASE - SRAML_SIZE;
	wire logic sramu_absent = a >= SAD_SRAMU_BASE + SRAMU_SIZE;
	wire logic flash_collide = !req_i.write && flash_cmd_busy_i;

	// Slot number; bit manipulation alias folds onto bridge slots by its low bits
	wire logic [6:0] bridge_slot = a[18:12];
	wire logic [6:0] bitman_slot = a[18:12];
	wire logic [7:0] slot_num = hit_gpio ? 8'h80 : {1'b0, hit_bitman ? bitman_slot : bridge_slot};
	// GPIO alias: slot 15 and slot 128 share enable and gate of slot 15
	wire logic [7:0] gate_num = (slot_num == 8'h80) ? {1'b0, SAD_GPIO_SLOT} : slot_num;
	wire logic slot_live = SLOT_PRESENT[slot_num] && slot_clk_gate_i[gate_num];
	wire logic offset_bad = a[11:0] > SLOT_SPAN;
	wire logic any_slot = hit_bridge | hit_gpio | hit_bitman;

	// Priority-free select: ranges are disjoint so only one can win
	sad_sel_type sel_raw;
	always_comb begin
		sel_raw = SAD_SEL_NONE;
		if (hit_flash) begin
			sel_raw = SAD_SEL_FLASH;
		end else if (hit_sraml) begin
			sel_raw = SAD_SEL_SRAML;
		end else if (hit_sramu) begin
			sel_raw = SAD_SEL_SRAMU;
		end else if (hit_bridge || hit_gpio) begin
			sel_raw = SAD_SEL_BRIDGE;
		end else if (hit_bitman) begin
			sel_raw = SAD_SEL_BITMAN;
		end else if (hit_ppb) begin
			sel_raw = SAD_SEL_PPB;
		end else if (hit_trace) begin
			sel_raw = SAD_SEL_TRACE;
		end else if (hit_direct) begin
			sel_raw = SAD_SEL_DIRECT;
		end
	end

	// Error sources
	wire logic err_reserved = sel_raw == SAD_SEL_NONE;
	wire logic err_master = req_i.is_dma && core_only;
	wire logic err_flash = hit_flash && (flash_absent || flash_collide);
	wire logic err_sram = (hit_sraml && sraml_absent) || (hit_sramu && sramu_absent);
	wire logic err_slot = any_slot && (!slot_live || offset_bad);
	wire logic err_any = err_reserved | err_master | err_flash | err_sram | err_slot;
	// Errored accesses select nothing
	wire sad_sel_type sel_final = err_any ? SAD_SEL_NONE : sel_raw;

	// Module enable vector: one bit at most, only for live slots
	logic [128:0] enable_d;
	always_comb begin
		enable_d = '0;
		if (req_i.valid && any_slot && !err_any) begin
			enable_d[gate_num] = 1'b1;
		end
	end

	// Full bit op set only via slot 15 alias; slot 128 gets a subset
	wire logic bitman_full_d = req_i.valid && hit_bitman && bitman_slot == SAD_GPIO_SLOT;

	sad_resp_type resp_d;
	always_comb begin
		resp_d = '0;
		resp_d.valid = req_i.valid;
		resp_d.sel = req_i.valid ? sel_final : SAD_SEL_NONE;
		resp_d.slot = any_slot ? slot_num : 8'h00;
		resp_d.offset = a[11:0];
		resp_d.vector = hit_flash && a < SAD_VECTOR_BYTES;
		resp_d.error = req_i.valid && err_any;
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			resp_o <= '0;
			slot_enable_o <= '0;
			bitman_gpio_full_o <= 1'b0;
		end else begin
			resp_o <= resp_d;
			slot_enable_o <= enable_d;
			bitman_gpio_full_o <= bitman_full_d;
		end
	end

	// Checks
	dma_core_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && core_only |=> resp_o.error && resp_o.sel == SAD_SEL_NONE)
		else $error("DMA reached a core-only range");
	one_enable_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$onehot0(slot_enable_o))
		else $error("More than one slot enable");
	err_no_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		resp_o.error |-> resp_o.sel == SAD_SEL_NONE && slot_enable_o == '0)
		else $error("Errored access selected a slave");
	flash_range_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && a < FLASH_SIZE && !flash_collide |=> resp_o.sel == SAD_SEL_FLASH)
		else $error("Present flash not selected");
	flash_absent_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_flash && flash_absent |=> resp_o.error)
		else $error("Absent flash did not error");
	collide_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_flash && !req_i.write && flash_cmd_busy_i |=> resp_o.error)
		else $error("Flash collision not errored");
	sram_absent_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && (hit_sraml && sraml_absent || hit_sramu && sramu_absent) |=> resp_o.error)
		else $error("Absent SRAM did not error");
	gate_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && any_slot && !slot_clk_gate_i[gate_num] |=> resp_o.error && !slot_enable_o[$past(gate_num)])
		else $error("Gated slot still enabled");
	gpio_alias_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_gpio && !err_any |=> slot_enable_o[SAD_GPIO_SLOT] && resp_o.slot == 8'h80)
		else $error("GPIO alias did not reach slot 15");
	vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && a == 32'h0000_00c3 |=> resp_o.vector)
		else $error("Vector byte not flagged");
	offset_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && any_slot && offset_bad |=> resp_o.error)
		else $error("Unimplemented offset not errored");

	// Map coverage and master rights
	full_space_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid |=> resp_o.sel != SAD_SEL_NONE || resp_o.error)
		else $error("Address neither selected nor errored");
	flash_base_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && a == SAD_FLASH_BASE && !flash_collide |=> resp_o.sel == SAD_SEL_FLASH)
		else $error("Flash base not selected");
	flash_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_flash && !flash_absent && !flash_collide
		|=> resp_o.sel == SAD_SEL_FLASH)
		else $error("DMA flash access refused");
	vector_end_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && a == SAD_VECTOR_BYTES |=> !resp_o.vector)
		else $error("Vector flag past the vector table");
	sraml_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_sraml && !sraml_absent |=> resp_o.sel == SAD_SEL_SRAML)
		else $error("Lower SRAM not selected");
	sramu_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_sramu && !sramu_absent |=> resp_o.sel == SAD_SEL_SRAMU)
		else $error("Upper SRAM not selected");
	sram_join_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && a == SAD_SRAMU_BASE - 32'h0000_0001 && !sraml_absent
		|=> resp_o.sel == SAD_SEL_SRAML && !resp_o.error)
		else $error("SRAM halves not contiguous");
	bridge_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && !err_any |=> resp_o.sel == SAD_SEL_BRIDGE)
		else $error("Bridge not selected");
	bridge_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_bridge && slot_live && !offset_bad |=> !resp_o.error)
		else $error("DMA refused at the bridge");
	direct_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && !req_i.is_dma && hit_direct
		|=> resp_o.sel == SAD_SEL_DIRECT && !resp_o.error)
		else $error("Direct GPIO port not selected");
	direct_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_direct |=> resp_o.error)
		else $error("DMA reached the direct GPIO port");
	bitman_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && !req_i.is_dma && hit_bitman && slot_live && !offset_bad
		|=> resp_o.sel == SAD_SEL_BITMAN)
		else $error("Bit manipulation alias not selected");
	bitman_slot_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bitman |=> resp_o.slot == {1'b0, $past(bitman_slot)})
		else $error("Alias slot number wrong");
	bitman_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_bitman |=> resp_o.error && slot_enable_o == '0)
		else $error("DMA reached the bit manipulation alias");
	bitman_full_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bitman && bitman_slot == SAD_GPIO_SLOT |=> bitman_gpio_full_o)
		else $error("Full bit op set not flagged on slot 15");
	bitman_subset_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_gpio |=> !bitman_gpio_full_o)
		else $error("Full bit op set flagged on slot 128");
	ppb_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && !req_i.is_dma && hit_ppb |=> resp_o.sel == SAD_SEL_PPB && !resp_o.error)
		else $error("Private range not selected for core");
	ppb_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_ppb |=> resp_o.error)
		else $error("DMA reached the private range");
	trace_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && !req_i.is_dma && hit_trace |=> resp_o.sel == SAD_SEL_TRACE && !resp_o.error)
		else $error("Trace range not selected for core");
	trace_dma_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.is_dma && hit_trace |=> resp_o.error)
		else $error("DMA reached the trace range");
	flash_write_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_flash && !flash_absent && req_i.write |=> !resp_o.error)
		else $error("Flash write refused");
	flash_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_flash && !flash_absent && !flash_cmd_busy_i |=> !resp_o.error)
		else $error("Idle flash read refused");
	sram_ok_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_sramu && !sramu_absent |=> !resp_o.error)
		else $error("Present SRAM refused");
	reserved_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && sel_raw == SAD_SEL_NONE |=> resp_o.error && slot_enable_o == '0)
		else $error("Reserved range not refused");

	// Slot decode
	onplat_en_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && !err_any && a[18:17] == 2'b00 |=> slot_enable_o[31:0] != '0)
		else $error("On-platform slot not enabled");
	onplat_slot_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && a[18:17] == 2'b00 |=> resp_o.slot < 8'h20)
		else $error("On-platform slot number wrong");
	offplat_en_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && !err_any && a[18:17] != 2'b00 |=> slot_enable_o[127:32] != '0)
		else $error("Off-platform slot not enabled");
	offplat_slot_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && a[18:17] != 2'b00
		|=> resp_o.slot >= 8'h20 && resp_o.slot <= 8'h7f)
		else $error("Off-platform slot number wrong");
	gpio_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_gpio && !err_any |=> resp_o.sel == SAD_SEL_BRIDGE)
		else $error("GPIO slot not routed to the bridge");
	gate_on_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && slot_live && !offset_bad |=> slot_enable_o[$past(gate_num)])
		else $error("Live slot not enabled");
	absent_slot_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && any_slot && !SLOT_PRESENT[slot_num] |=> resp_o.error && slot_enable_o == '0)
		else $error("Absent slot not refused");
	offset_ok_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid && hit_bridge && slot_live && !offset_bad |=> !resp_o.error)
		else $error("Implemented offset refused");

	// Quiet when idle, never two slaves
	idle_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!req_i.valid |=> !resp_o.valid && !resp_o.error && slot_enable_o == '0 && !bitman_gpio_full_o)
		else $error("Output active without a request");
	valid_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		req_i.valid |=> resp_o.valid)
		else $error("Request not answered next cycle");
	sel_valid_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!resp_o.valid |-> resp_o.sel == SAD_SEL_NONE)
		else $error("Slave selected without a request");
	enable_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		slot_enable_o != '0 |-> resp_o.sel == SAD_SEL_BRIDGE || resp_o.sel == SAD_SEL_BITMAN)
		else $error("Slot enabled for a non-slot slave");
	no_slot128_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!slot_enable_o[128])
		else $error("Slot 128 enabled apart from slot 15");
endmodule // sad_decoder

// Inclusive window compare on the bus address
module sad_range_hit #(
	parameter logic [31:0] LO = 32'h0000_0000,
	parameter logic [31:0] HI = 32'hffff_ffff
) (
	// Address under test
	input wire logic [31:0] addr_i,
	// Inside the window
	output logic hit_o
);
	// A zero low bound always holds; short-circuit it
	wire logic above_lo = (LO == 32'h0000_0000) || (addr_i >= LO);
	wire logic below_hi = addr_i <= HI;
	assign hit_o = above_lo && below_hi;
endmodule // sad_range_hit

// ---- dv/sad_master_model.sv ----
// Bus master model for the decoder: core or DMA requester
`timescale 1ns/1ps
module sad_master_model
	import sad_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Request toward the decoder
	output sad_req_type req_o
);
	initial req_o = '0;
	// Request held until the next call, so back-to-back is possible
	task automatic issue(input logic dma, input logic wr, input logic [31:0] a);
		@(posedge sys_clk_i);
		req_o <= '{valid: 1'b1, is_dma: dma, write: wr, addr: a};
	endtask
	// Released bus shows inverted junk, never the stale address
	task automatic idle();
		@(posedge sys_clk_i);
		req_o <= '{1'b0, ~req_o.is_dma, ~req_o.write, ~req_o.addr};
	endtask
endmodule // sad_master_model

// ---- dv/testbench.sv ----
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
module testbench;
	import sad_pkg::*;
	typedef struct packed {
		logic d;
		logic w;
		logic [31:0] a;
		sad_sel_type s;
		logic [7:0] sl;
		logic e;
	} sad_row_type;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [128:0] gate = {129{1'b1}};
	logic busy = 1'b0;
	sad_req_type req;
	sad_resp_type resp_o;
	logic [128:0] slot_enable_o;
	logic bitman_gpio_full_o;
	int n_fail = 0;
	int n_compared = 0;
	sad_row_type rows [22];
	always #50 sys_clk_i = ~sys_clk_i;
	sad_master_model u_sad_master_model (.sys_clk_i(sys_clk_i), .req_o(req));
	// Slot 3 absent, only 256 bytes per slot implemented
	sad_decoder #(.SLOT_PRESENT({{125{1'b1}}, 1'b0, 3'b111}), .SLOT_SPAN(12'h0ff)) u_sad_decoder (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req), .slot_clk_gate_i(gate),
		.flash_cmd_busy_i(busy), .resp_o(resp_o), .slot_enable_o(slot_enable_o),
		.bitman_gpio_full_o(bitman_gpio_full_o));
	task automatic chk(input string n, input logic [128:0] x, input logic [128:0] g);
		n_compared++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic step(input sad_row_type r);
		u_sad_master_model.issue(r.d, r.w, r.a);
		@(posedge sys_clk_i);
		#1;
		chk("valid", 1, resp_o.valid);
		chk("sel", r.s, resp_o.sel);
		chk("error", r.e, resp_o.error);
		if (!r.e) begin
			chk("slot", r.sl, resp_o.slot);
			chk("offset", r.a[11:0], resp_o.offset);
			chk("vector", r.s == SAD_SEL_FLASH && r.a < SAD_VECTOR_BYTES, resp_o.vector);
		end
		if (r.s != SAD_SEL_BITMAN)
			chk("enable", (r.s == SAD_SEL_BRIDGE) ? 129'h1 << (r.sl == 8'h80 ? 15 : r.sl) : 0,
				slot_enable_o);
		chk("bitman_full", r.s == SAD_SEL_BITMAN && r.sl == {1'b0, SAD_GPIO_SLOT},
			bitman_gpio_full_o);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_fail++;
		stop_test();
	end
	initial begin
		rows = '{'{0, 0, 32'h0000_0000, SAD_SEL_FLASH, 0, 0}, '{0, 0, 32'h0000_00c4, SAD_SEL_FLASH, 0, 0},
			'{0, 0, 32'h0000_8000, SAD_SEL_NONE, 0, 1}, '{1, 0, 32'h1fff_fc00, SAD_SEL_SRAML, 0, 0},
			'{1, 1, 32'h2000_0bff, SAD_SEL_SRAMU, 0, 0}, '{0, 0, 32'h2000_0c00, SAD_SEL_NONE, 0, 1},
			'{1, 0, 32'h4000_00f0, SAD_SEL_BRIDGE, 0, 0}, '{0, 1, 32'h4001_f000, SAD_SEL_BRIDGE, 31, 0},
			'{1, 0, 32'h4002_0004, SAD_SEL_BRIDGE, 32, 0}, '{0, 0, 32'h4007_f0fc, SAD_SEL_BRIDGE, 127, 0},
			'{1, 0, 32'h400f_f010, SAD_SEL_BRIDGE, 128, 0}, '{0, 0, 32'h4008_0000, SAD_SEL_NONE, 0, 1},
			'{0, 0, 32'h4400_f000, SAD_SEL_BITMAN, 15, 0}, '{1, 0, 32'h4400_0000, SAD_SEL_NONE, 0, 1},
			'{0, 0, 32'he000_0000, SAD_SEL_PPB, 0, 0}, '{1, 0, 32'he000_0000, SAD_SEL_NONE, 0, 1},
			'{0, 0, 32'hf000_3000, SAD_SEL_TRACE, 0, 0}, '{0, 0, 32'hf000_4000, SAD_SEL_NONE, 0, 1},
			'{0, 0, 32'hf800_0000, SAD_SEL_DIRECT, 0, 0}, '{1, 0, 32'hffff_fffc, SAD_SEL_NONE, 0, 1},
			'{0, 1, 32'h4000_8010, SAD_SEL_BRIDGE, 8, 0}, '{0, 0, 32'h4000_8010, SAD_SEL_BRIDGE, 8, 0}};
		repeat (10) @(posedge sys_clk_i);
		chk("reset_resp", 0, resp_o);
		chk("reset_enable", 0, slot_enable_o);
		rstn_i <= 1'b1;
		foreach (rows[i]) step(rows[i]);
		step('{0, 0, 32'h4000_1100, SAD_SEL_NONE, 0, 1});
		step('{1, 0, 32'h4000_3000, SAD_SEL_NONE, 0, 1});
		@(posedge sys_clk_i) busy <= 1'b1;
		step('{0, 0, 32'h0000_0100, SAD_SEL_NONE, 0, 1});
		step('{1, 1, 32'h0000_0100, SAD_SEL_FLASH, 0, 0});
		@(posedge sys_clk_i) gate[56] <= 1'b0;
		gate[15] <= 1'b0;
		step('{0, 0, 32'h4003_8000, SAD_SEL_NONE, 0, 1});
		step('{1, 0, 32'h400f_f000, SAD_SEL_NONE, 0, 1});
		step('{0, 0, 32'h4000_f000, SAD_SEL_NONE, 0, 1});
		@(posedge sys_clk_i) rstn_i <= 1'b0;
		#1;
		chk("midrun_reset", 0, resp_o.valid);
		chk("midrun_enable", 0, slot_enable_o);
		u_sad_master_model.idle();
		rstn_i <= 1'b1;
		step('{0, 0, 32'he000_0000, SAD_SEL_PPB, 0, 0});
		stop_test();
	end
endmodule // testbench
